// ==== core/adirq_pkg.sv ====
// Package: register map, field layout, timing and carrier types of the interrupt pulse block
package adirq_pkg;

  // ***************************************************
  // Register offsets
  // ***************************************************
  localparam logic [7:0] ADDR_STICKY = 8'h2C;
  localparam logic [7:0] ADDR_LIVE   = 8'h2E;
  localparam logic [7:0] ADDR_RSVD   = 8'h2F;
  localparam logic [7:0] ADDR_CTRL1  = 8'h30;
  localparam logic [7:0] ADDR_CTRL2  = 8'h31;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] RSVD_VALUE  = 8'h00;

  // ***************************************************
  // Field positions
  // ***************************************************
  // Status bits, shared by live and sticky registers
  localparam int ST_SHORT_L = 7;
  localparam int ST_SHORT_R = 6;
  localparam int ST_BUTTON  = 5;
  localparam int ST_HEADSET = 4;
  localparam int ST_DRC_L   = 3;
  localparam int ST_DRC_R   = 2;
  // Routing control bits
  localparam int CT_HEADSET = 7;
  localparam int CT_BUTTON  = 6;
  localparam int CT_DRC     = 5;
  localparam int CT_SHORT   = 3;
  localparam int CT_OVF     = 2;
  localparam int CT_REPEAT  = 0;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_HZ     = 25000000;
  localparam int PULSE_MS   = 2;
  localparam int PERIOD_MS  = 4;
  localparam int PULSE_CYC  = CLK_HZ / 1000 * PULSE_MS;
  localparam int PERIOD_CYC = CLK_HZ / 1000 * PERIOD_MS;
  localparam int CNT_W      = 17;
  localparam int NUM_OUT    = 2;

  // ***************************************************
  // Types
  // ***************************************************
  typedef enum logic [1:0] {
    ADIRQ_IDLE = 2'b00,
    ADIRQ_HIGH = 2'b01,
    ADIRQ_LOW  = 2'b10
  } adirq_state_t;

  // Levels and pulses from the detection circuits
  typedef struct packed {
    logic short_left;
    logic short_right;
    logic button;
    logic headset;
    logic drc_left;
    logic drc_right;
    logic dac_overflow;
  } adirq_src_t;

  // One register access from the control port
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adirq_req_t;

endpackage

// ==== core/adirq_pulse_gen.sv ====
// Module: interrupt status registers and two routed interrupt pulse outputs
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Live bits 5,4 show button, headset
// - Live bit 3 shows left power above threshold
// - Live bit 2 right power; bits 1:0 zero
// - First control bits 7,6,5,3 enable sources
// - Overflow reaches first output only if bit2
// - First output single 2 ms pulse if bit0=0
// - First output repeats 2/4 ms until sticky read
// - Second control bits 7,6,5,3 enable sources
// - Overflow reaches second output only if bit2
// - Second output single 2 ms pulse if bit0=0
// - Second output repeats until sticky read
// - Sticky flags clear on read, set again
// - Live bits 7,6 show short circuits
module adirq_pulse_gen
  import adirq_pkg::*;
#(
  parameter int PULSE_CYCLES  = PULSE_CYC,
  parameter int PERIOD_CYCLES = PERIOD_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire adirq_src_t src_in,
  input  wire adirq_req_t req_in,
  output var  logic [7:0] reg_rdata,
  output var  logic       first_irq_output,
  output var  logic       second_irq_output
);

  // ***************************************************
  // Source edges and live status
  // ***************************************************
  adirq_src_t   src_prev_reg;
  logic [7:0]   live_status;
  logic [7:0]   sticky_reg;
  logic [7:0]   sticky_set;
  logic [7:0]   ctrl_reg [NUM_OUT];
  logic [4:0]   event_vec;
  logic [NUM_OUT-1:0] trig;
  logic [NUM_OUT-1:0] armed_reg;
  logic [NUM_OUT-1:0] irq_reg;
  logic [CNT_W-1:0]   cnt_reg [NUM_OUT];
  adirq_state_t state_reg [NUM_OUT];
  logic [7:0]   rdata_next;

  // All checks run on the one clock and rest while reset is high
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  wire rd_sticky = req_in.rd && (req_in.addr == ADDR_STICKY);
  wire rd_live   = req_in.rd && (req_in.addr == ADDR_LIVE);
  wire wr_ctrl1  = req_in.wr && (req_in.addr == ADDR_CTRL1);
  wire wr_ctrl2  = req_in.wr && (req_in.addr == ADDR_CTRL2);

  // Live view of the detectors; low two bits are hard zero
  assign live_status = {src_in.short_left, src_in.short_right,
                        src_in.button, src_in.headset,
                        src_in.drc_left,
                        src_in.drc_right, 2'b00};

  // Rising edges, plus both edges of the headset level
  wire ev_short_l = src_in.short_left  && !src_prev_reg.short_left;
  wire ev_short_r = src_in.short_right && !src_prev_reg.short_right;
  wire ev_button  = src_in.button      && !src_prev_reg.button;
  wire ev_headset = src_in.headset     ^  src_prev_reg.headset;
  wire ev_drc_l   = src_in.drc_left    && !src_prev_reg.drc_left;
  wire ev_drc_r   = src_in.drc_right   && !src_prev_reg.drc_right;

  assign sticky_set = {ev_short_l, ev_short_r, ev_button, ev_headset,
                       ev_drc_l, ev_drc_r, 2'b00};
  // Event order matches the enable bits 7,6,5,3,2
  assign event_vec  = {ev_headset, ev_button, ev_drc_l || ev_drc_r,
                       ev_short_l || ev_short_r, src_in.dac_overflow};

  // Previous source levels for edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      src_prev_reg <= '0;
    end else begin
      src_prev_reg <= src_in;
    end
  end

  // ***************************************************
  // Sticky flags and routing control
  // ***************************************************
  // A new event in the read cycle survives the clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sticky_reg <= 8'h00;
    end else begin
      sticky_reg <= (rd_sticky ? 8'h00 : sticky_reg) | sticky_set;
    end
  end

  // Reserved bits are stored as written; software keeps them zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg[0] <= CTRL_RESET;
      ctrl_reg[1] <= CTRL_RESET;
    end else begin
      if (wr_ctrl1) begin
        ctrl_reg[0] <= req_in.wdata;
      end
      if (wr_ctrl2) begin
        ctrl_reg[1] <= req_in.wdata;
      end
    end
  end

  // ***************************************************
  // Read data
  // ***************************************************
  // Unmapped and reserved offsets read as zero
  assign rdata_next = rd_sticky                       ? sticky_reg  :
                      rd_live                         ? live_status :
                      (req_in.addr == ADDR_CTRL1)     ? ctrl_reg[0] :
                      (req_in.addr == ADDR_CTRL2)     ? ctrl_reg[1] : RSVD_VALUE;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (req_in.rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // ***************************************************
  // Per-output trigger and pulse generator
  // ***************************************************
  generate
    for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
      logic [4:0]       en_mask;
      adirq_state_t     state_next;
      logic [CNT_W-1:0] cnt_next;
      wire              pulse_end  = (cnt_reg[g] == CNT_W'(PULSE_CYCLES - 1));
      wire              period_end = (cnt_reg[g] == CNT_W'(PERIOD_CYCLES - 1));
      wire              repeat_on  = ctrl_reg[g][CT_REPEAT];

      // Overflow counts only with its own enable bit
      assign en_mask = {ctrl_reg[g][CT_HEADSET], ctrl_reg[g][CT_BUTTON],
                        ctrl_reg[g][CT_DRC], ctrl_reg[g][CT_SHORT],
                        ctrl_reg[g][CT_OVF]};
      assign trig[g] = |(event_vec & en_mask);

      // A pulse in flight is not restarted by a new event
      always_comb begin
        state_next = state_reg[g];
        cnt_next   = cnt_reg[g] + CNT_W'(1);
        case (state_reg[g])
          ADIRQ_IDLE: begin
            cnt_next = '0;
            if (trig[g]) begin
              state_next = ADIRQ_HIGH;
            end
          end
          ADIRQ_HIGH: begin
            if (pulse_end) begin
              state_next = repeat_on ? ADIRQ_LOW : ADIRQ_IDLE;
            end
          end
          ADIRQ_LOW: begin
            if (period_end) begin
              cnt_next   = '0;
              state_next = (repeat_on && armed_reg[g]) ? ADIRQ_HIGH : ADIRQ_IDLE;
            end
          end
          default: begin
            state_next = ADIRQ_IDLE;
            cnt_next   = '0;
          end
        endcase
      end

      // Repeats stay armed until the sticky register is read
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          state_reg[g] <= ADIRQ_IDLE;
          cnt_reg[g]   <= '0;
          armed_reg[g] <= 1'b0;
          irq_reg[g]   <= 1'b0;
        end else begin
          state_reg[g] <= state_next;
          cnt_reg[g]   <= cnt_next;
          armed_reg[g] <= trig[g] || (armed_reg[g] && !rd_sticky);
          irq_reg[g]   <= (state_next == ADIRQ_HIGH);
        end
      end
    end
  endgenerate

  assign first_irq_output  = irq_reg[0];
  assign second_irq_output = irq_reg[1];

  // ***************************************************
  // Assertions
  // ***************************************************

  // Helper: length of each high phase
  logic [CNT_W-1:0] hi_cnt_reg [NUM_OUT];
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hi_cnt_reg[0] <= '0;
      hi_cnt_reg[1] <= '0;
    end else begin
      hi_cnt_reg[0] <= irq_reg[0] ? hi_cnt_reg[0] + CNT_W'(1) : '0;
      hi_cnt_reg[1] <= irq_reg[1] ? hi_cnt_reg[1] + CNT_W'(1) : '0;
    end
  end

  property p_live_read;
    rd_live |=> reg_rdata[1:0] == 2'b00 && reg_rdata[7] == $past(src_in.short_left)
                && reg_rdata[3] == $past(src_in.drc_left);
  endproperty
  a_live_read: assert property (p_live_read) else $error("live status read wrong");

  property p_ctrl1_readback;
    wr_ctrl1 ##1 !wr_ctrl1 ##1 (req_in.rd && req_in.addr == ADDR_CTRL1 && !wr_ctrl1)
      |=> reg_rdata == $past(req_in.wdata, 3);
  endproperty
  a_ctrl1_readback: assert property (p_ctrl1_readback) else $error("ctrl1 readback");

  property p_sticky_clear;
    rd_sticky && sticky_set == 8'h00 |=> sticky_reg == 8'h00;
  endproperty
  a_sticky_clear: assert property (p_sticky_clear) else $error("sticky not cleared");

  property p_set_wins;
    rd_sticky && ev_short_l |=> sticky_reg[ST_SHORT_L];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on read");

  property p_ovf_first;
    state_reg[0] == ADIRQ_IDLE && src_in.dac_overflow && ctrl_reg[0][CT_OVF]
      |=> first_irq_output;
  endproperty
  a_ovf_first: assert property (p_ovf_first) else $error("overflow missed out 1");

  property p_ovf_second_off;
    state_reg[1] == ADIRQ_IDLE && !ctrl_reg[1][CT_OVF]
      && (event_vec[4:1] & {ctrl_reg[1][7:5], ctrl_reg[1][3]}) == 4'h0
      |=> !second_irq_output;
  endproperty
  a_ovf_second_off: assert property (p_ovf_second_off) else $error("out 2 spurious");

  property p_width_first;
    $fell(first_irq_output) |-> hi_cnt_reg[0] == CNT_W'(PULSE_CYCLES);
  endproperty
  a_width_first: assert property (p_width_first) else $error("out 1 width");

  property p_width_second;
    $fell(second_irq_output) |-> hi_cnt_reg[1] == CNT_W'(PULSE_CYCLES);
  endproperty
  a_width_second: assert property (p_width_second) else $error("out 2 width");

  wire period_end_0 = (cnt_reg[0] == CNT_W'(PERIOD_CYCLES - 1));
  wire repeat_0     = ctrl_reg[0][CT_REPEAT];
  property p_repeat_first;
    state_reg[0] == ADIRQ_LOW && period_end_0 && repeat_0 && armed_reg[0]
      |=> first_irq_output ##1 first_irq_output;
  endproperty
  a_repeat_first: assert property (p_repeat_first) else $error("out 1 no repeat");

  property p_stop_second;
    rd_sticky && !trig[1] |=> !armed_reg[1];
  endproperty
  a_stop_second: assert property (p_stop_second) else $error("out 2 still armed");

  c_single_pulse: cover property ($fell(first_irq_output) && !ctrl_reg[0][CT_REPEAT]);
  c_repeat_pulse: cover property (state_reg[1] == ADIRQ_LOW ##1 state_reg[1] == ADIRQ_HIGH);
  c_set_on_read:  cover property (rd_sticky && sticky_set != 8'h00);
  c_both_outputs: cover property (first_irq_output && second_irq_output);

endmodule

`default_nettype wire

// ==== tb/adirq_host_model.sv ====
// Host model: byte accesses on the control port of the interrupt block
`timescale 1ns/100ps
`default_nettype none
module adirq_host_model
  import adirq_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output var  adirq_req_t req_in
);
  // ***************************************************
  // Accesses
  // ***************************************************
  initial req_in = '0;

  // Write one byte; reserved control bits are always sent as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req_in <= '{1'b0, 1'b1, a, d & 8'hED};
    @(negedge sys_clk);
    req_in <= '{1'b0, 1'b0, ~a, ~d}; // Stale fields inverted so nothing leans on them
  endtask

  // Read one byte; data is taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge sys_clk);
    req_in <= '{1'b1, 1'b0, a, 8'h00};
    @(negedge sys_clk);
    q = reg_rdata;
    req_in <= '{1'b0, 1'b0, ~a, 8'hA5};
  endtask
endmodule
`default_nettype wire

// ==== tb/adirq_pulse_gen_bench.sv ====
// Testbench: registers and both interrupt outputs of the pulse block
`timescale 1ns/100ps
`default_nettype none
module adirq_pulse_gen_bench;
  import adirq_pkg::*;
  localparam int PW = 8;
  localparam int PP = 16;
  logic        sys_clk;
  logic        rst;
  adirq_src_t  src;
  adirq_req_t  req;
  logic [7:0]  rdata;
  logic [7:0]  q;
  logic [7:0]  a;
  logic [1:0]  irq;
  logic [31:0] seed;
  int          err_count;
  int          cmp_count;
  int          hi [2];
  int          rs [2];
  int          sb [4] = '{3, 4, 1, 5};
  logic [7:0]  cb [4] = '{8'h80, 8'h40, 8'h20, 8'h08};

  adirq_pulse_gen #(.PULSE_CYCLES(PW), .PERIOD_CYCLES(PP)) u_dut (.sys_clk(sys_clk),
    .rst(rst), .src_in(src), .req_in(req), .reg_rdata(rdata),
    .first_irq_output(irq[0]), .second_irq_output(irq[1]));
  adirq_host_model u_host (.sys_clk(sys_clk), .reg_rdata(rdata), .req_in(req));

  // ***************************************************
  // Clock, helpers
  // ***************************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Live image expected from the source levels
  function automatic logic [7:0] live_of(input logic [6:0] s);
    return {s[6:1], 2'b00};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Count high cycles and rising edges of both outputs, sampled mid-cycle
  // Starts before the output can rise, and ends the overflow strobe after one cycle
  task automatic watch(input int n);
    logic [1:0] prev;
    prev = irq;
    hi = '{0, 0};
    rs = '{0, 0};
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      if (i == 0) src.dac_overflow <= 1'b0;
      for (int j = 0; j < 2; j++) begin
        if (irq[j] === 1'b1) hi[j]++;
        if (irq[j] === 1'b1 && prev[j] !== 1'b1) rs[j]++;
      end
      prev = irq;
    end
  endtask

  // Raise the overflow strobe; the following watch lowers it
  task automatic ovf;
    @(negedge sys_clk);
    src.dac_overflow <= 1'b1;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    test_done();
  end

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    src = '0;
    rst = 1'b1;
    err_count = 0;
    cmp_count = 0;
    seed = 32'h9BA1FB8C;
    repeat (20) @(negedge sys_clk);
    rst <= 1'b0;
    u_host.rd(ADDR_CTRL1, q); check(q, CTRL_RESET);
    u_host.rd(ADDR_CTRL2, q); check(q, CTRL_RESET);
    u_host.wr(ADDR_LIVE, 8'hFF);
    u_host.rd(ADDR_LIVE, q); check(q, 8'h00);
    u_host.rd(ADDR_RSVD, q); check(q, RSVD_VALUE);
    // Live bits follow random levels; controls at zero keep outputs quiet
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      src <= adirq_src_t'({seed[6:1], 1'b0});
      u_host.rd(ADDR_LIVE, q); check(q, live_of({seed[6:1], 1'b0}));
    end
    src <= '0;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      u_host.wr(ADDR_CTRL1, seed[7:0]);
      u_host.rd(ADDR_CTRL1, q); check(q, seed[7:0] & 8'hED);
      u_host.wr(ADDR_CTRL2, seed[15:8]);
      u_host.rd(ADDR_CTRL2, q); check(q, seed[15:8] & 8'hED);
    end
    u_host.wr(ADDR_CTRL1, 8'h00);
    u_host.wr(ADDR_CTRL2, 8'h00);
    // Overflow gating, single pulse, repeat until the sticky read
    for (int j = 0; j < 2; j++) begin
      a = (j == 0) ? ADDR_CTRL1 : ADDR_CTRL2;
      ovf(); watch(30); check(8'(rs[j]), 8'h00);
      u_host.wr(a, 8'h04);
      ovf(); watch(30); check(8'(hi[j]), 8'(PW));
      check(8'(rs[j] * 16 + rs[1 - j]), 8'h10);
      u_host.wr(a, 8'h05);
      ovf(); watch(36); check(8'(rs[j]), 8'h03);
      u_host.rd(ADDR_STICKY, q);
      watch(40); check(8'(rs[j]), 8'h00);
      u_host.wr(a, 8'h00);
    end
    // Only enabled sources fire; sticky flags clear on read
    u_host.rd(ADDR_STICKY, q);
    u_host.wr(ADDR_CTRL1, 8'h40);
    src.drc_left <= 1'b1; watch(20); check(8'(rs[0]), 8'h00);
    src.button <= 1'b1; watch(20); check(8'(rs[0]), 8'h01);
    u_host.rd(ADDR_STICKY, q); check(q, 8'h28);
    u_host.rd(ADDR_STICKY, q); check(q, 8'h00);
    // A short rising in the very cycle of the read must survive the clear
    fork
      u_host.rd(ADDR_STICKY, q);
      begin
        @(negedge sys_clk);
        src.short_left <= 1'b1;
      end
    join
    check(q, 8'h00);
    u_host.rd(ADDR_STICKY, q); check(q, 8'h80);
    u_host.wr(ADDR_CTRL1, 8'h00);
    src <= '0;
    watch(4);
    // Each of the source enables 7,6,5,3 of the second output in turn
    for (int k = 0; k < 4; k++) begin
      u_host.wr(ADDR_CTRL2, cb[k]);
      src[sb[k]] <= 1'b1; watch(20); check(8'(rs[1]), 8'h01);
      u_host.wr(ADDR_CTRL2, 8'h00);
    end
    test_done();
  end
endmodule
`default_nettype wire
